//--- rtl/prx_pkg.sv
// package for the processor register stack: layout, kinds, field positions
// assumes one processor clock; all users import prx_pkg::*
package prx_pkg;
    localparam int WORD_W    = 32;
    localparam int DWORD_W   = 64;
    localparam int BYTE_W    = 8;
    localparam int STK_DEPTH = 48;
    localparam int IDX_W     = 6;
    localparam int NUM_W     = 4;
    localparam int RELOC_W   = 20;
    localparam int ADDR_W    = 24;
    localparam int AMT_W     = 6;

    localparam logic [IDX_W-1:0] SUP_BASE  = 6'h00;
    localparam logic [IDX_W-1:0] PROB_BASE = 6'h10;
    localparam logic [IDX_W-1:0] FP_BASE   = 6'h20;
    localparam logic [IDX_W-1:0] WORK_BASE = 6'h28;
    localparam logic [IDX_W-1:0] IDX_STEP  = 6'h01;

    // bit 0 is the msb of any field; numbering grows toward the lsb
    function automatic int ibit(input int width, input int n);
        return width - 1 - n;
    endfunction

    localparam int SIGN_POS    = ibit(WORD_W, 0);
    localparam int FP_CHAR_HI  = ibit(WORD_W, 1);
    localparam int FP_CHAR_LO  = ibit(WORD_W, 7);
    localparam int FP_CHAR_W   = 7;
    localparam int NIB_W       = 4;
    localparam logic [BYTE_W-1:0] FP_BIAS = 8'h40;

    localparam logic [1:0] ILEN_NONE   = 2'h0;
    localparam logic [4:0] DEC_LEN_MIN = 5'h01;
    localparam logic [4:0] DEC_LEN_MAX = 5'h10;

    typedef enum logic [5:0] {
        K_GEN  = 6'h01,
        K_BYTE = 6'h02,
        K_PAIR = 6'h04,
        K_FPS  = 6'h08,
        K_FPL  = 6'h10,
        K_WORK = 6'h20
    } prx_kind_t;

    typedef enum logic [5:0] {
        U_BYTE  = 6'h01,
        U_HALF  = 6'h02,
        U_WORD  = 6'h04,
        U_DBL   = 6'h08,
        U_INSTR = 6'h10,
        U_VAR   = 6'h20
    } prx_unit_t;
endpackage

//--- rtl/prx_fmt_if.sv
// carrier between the register stack and its format/alignment decoder
// assumes both ends sit in the processor clock domain
`timescale 1ns/100ps
interface prx_fmt_if;
    import prx_pkg::*;
    logic [ADDR_W-1:0]    chk_addr;
    prx_unit_t            chk_unit;
    logic [1:0]           chk_ilen;
    logic [4:0]           chk_dlen;
    logic                 misalign;
    logic                 len_bad;
    logic [WORD_W-1:0]    opw;
    logic                 dec_packed;
    logic                 fix_neg;
    logic [FP_CHAR_W-1:0] fp_char;
    logic [BYTE_W-1:0]    fp_exp;
    logic [NIB_W-1:0]     dec_sign;

    modport stk (output chk_addr, chk_unit, chk_ilen, chk_dlen, opw, dec_packed,
                 input misalign, len_bad, fix_neg, fp_char, fp_exp, dec_sign);
    modport fmt (input chk_addr, chk_unit, chk_ilen, chk_dlen, opw, dec_packed,
                 output misalign, len_bad, fix_neg, fp_char, fp_exp, dec_sign);
endinterface

//--- rtl/prx_fmt.sv
// combinational operand format decoder and storage alignment checker
// assumes the stack registers every result it takes from here
`timescale 1ns/100ps
module prx_fmt
(
    prx_fmt_if.fmt f
);
    import prx_pkg::*;

    wire [2:0] lsb      = f.chk_addr[2:0];
    wire       is_half  = (f.chk_unit == U_HALF);
    wire       is_instr = (f.chk_unit == U_INSTR);
    wire       is_word  = (f.chk_unit == U_WORD);
    wire       is_dbl   = (f.chk_unit == U_DBL);
    wire       is_var   = (f.chk_unit == U_VAR);

    // byte and variable fields start anywhere, so they never raise the flag
    assign f.misalign = ((is_half | is_instr) & lsb[0])
                      | (is_word & (|lsb[1:0]))
                      | (is_dbl & (|lsb));

    wire ilen_bad = is_instr & (f.chk_ilen == ILEN_NONE);
    wire dlen_bad = is_var & ((f.chk_dlen < DEC_LEN_MIN) | (f.chk_dlen > DEC_LEN_MAX));
    assign f.len_bad = ilen_bad | dlen_bad;

    assign f.fix_neg  = f.opw[SIGN_POS];
    assign f.fp_char  = f.opw[FP_CHAR_HI:FP_CHAR_LO];
    assign f.fp_exp   = {1'b0, f.fp_char} - FP_BIAS;
    // packed keeps the sign in the low nibble, unpacked in the last zone
    assign f.dec_sign = f.dec_packed ? f.opw[NIB_W-1:0]
                                     : f.opw[BYTE_W-1:NIB_W];
endmodule

//--- rtl/prx_regstack.sv
// processor register stack: 48 words plus the relocation register
// assumes control supplies implicit working indices and one command per kind a cycle
`timescale 1ns/100ps

module prx_regstack
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      problem_state_bit,
    input  wire logic                      wr_en,
    input  wire prx_pkg::prx_kind_t        wr_kind,
    input  wire logic [prx_pkg::NUM_W-1:0] wr_num,
    input  wire logic                      wr_half,
    input  wire logic [prx_pkg::WORD_W-1:0] wr_data,
    input  wire logic                      rd_en,
    input  wire prx_pkg::prx_kind_t        rd_kind,
    input  wire logic [prx_pkg::NUM_W-1:0] rd_num,
    input  wire logic                      rd_half,
    input  wire logic                      dec_packed,
    input  wire logic                      sh_en,
    input  wire logic [prx_pkg::NUM_W-1:0] sh_num,
    input  wire logic                      sh_left,
    input  wire logic                      sh_arith,
    input  wire logic [prx_pkg::AMT_W-1:0] sh_amt,
    input  wire logic                      reloc_wr,
    input  wire logic [prx_pkg::RELOC_W-1:0] reloc_data,
    input  wire logic                      chk_en,
    input  wire prx_pkg::prx_unit_t        chk_unit,
    input  wire logic [prx_pkg::ADDR_W-1:0] chk_addr,
    input  wire logic [1:0]                chk_ilen,
    input  wire logic [4:0]                chk_dlen,
    output logic [prx_pkg::WORD_W-1:0]     rd_data_q,
    output logic                           rd_valid_q,
    output logic                           rd_err_q,
    output logic                           rd_neg_q,
    output logic [prx_pkg::FP_CHAR_W-1:0]  rd_fp_char_q,
    output logic [prx_pkg::BYTE_W-1:0]     rd_fp_exp_q,
    output logic [prx_pkg::NIB_W-1:0]      rd_dec_sign_q,
    output logic                           wr_err_q,
    output logic                           sh_err_q,
    output logic [prx_pkg::RELOC_W-1:0]    reloc_q,
    output logic                           chk_valid_q,
    output logic                           misalign_q,
    output logic                           len_err_q
);
    import prx_pkg::*;

    // maps a program register reference onto a hardware word: {legal, index}
    function automatic logic [IDX_W:0] hw_map(input prx_kind_t k,
                                              input logic [NUM_W-1:0] n,
                                              input logic h,
                                              input logic p);
        logic [IDX_W-1:0] bank;
        bank = p ? PROB_BASE : SUP_BASE;
        case (k)
            K_GEN, K_BYTE:
                hw_map = {1'b1, bank + {2'h0, n}};
            K_PAIR:
                hw_map = {~n[0], bank + {2'h0, n[3:1], h}};
            K_FPS:
                hw_map = {~n[0] & ~n[3], FP_BASE + {2'h0, n[3:1], 1'b0}};
            K_FPL:
                hw_map = {~n[0] & ~n[3], FP_BASE + {2'h0, n[3:1], h}};
            K_WORK:
                hw_map = {~n[3], WORK_BASE + {3'h0, n[2:0]}};
            default:
                hw_map = {1'b0, SUP_BASE};
        endcase
    endfunction

    logic [WORD_W-1:0] stk_q [0:STK_DEPTH-1];

    // read and write ports are one word wide; double words move as two beats, except a shift, which moves the whole pair in one cycle
    wire [IDX_W:0]      w_map = hw_map(wr_kind, wr_num, wr_half, problem_state_bit);
    wire [IDX_W:0]      r_map = hw_map(rd_kind, rd_num, rd_half, problem_state_bit);
    wire [IDX_W:0]      s_map = hw_map(K_PAIR, sh_num, 1'b0, problem_state_bit);
    wire                w_ok  = w_map[IDX_W];
    wire                r_ok  = r_map[IDX_W];
    wire                s_ok  = s_map[IDX_W];
    wire [IDX_W-1:0]    w_idx = w_map[IDX_W-1:0];
    wire [IDX_W-1:0]    r_idx = r_map[IDX_W-1:0];
    wire [IDX_W-1:0]    s_idx = s_map[IDX_W-1:0];
    wire [IDX_W-1:0]    s_odd = s_idx + IDX_STEP;

    // a shift owns both write paths, so a write in the same cycle is refused
    wire                sh_fire = sh_en & s_ok;
    wire                wr_fire = wr_en & w_ok & ~sh_en;

    wire [WORD_W-1:0]   w_word = (wr_kind == K_BYTE)
                               ? {stk_q[w_idx][WORD_W-1:BYTE_W], wr_data[BYTE_W-1:0]}
                               : wr_data;

    wire [DWORD_W-1:0]  s_opnd = {stk_q[s_idx], stk_q[s_odd]};
    wire [DWORD_W-1:0]  s_shl  = s_opnd << sh_amt;
    wire [DWORD_W-1:0]  s_shr  = s_opnd >> sh_amt;
    wire [DWORD_W-1:0]  s_sra  = $signed(s_opnd) >>> sh_amt;
    // arithmetic left keeps the sign in place, as two's complement needs
    wire [DWORD_W-1:0]  s_sla  = {s_opnd[DWORD_W-1], s_shl[DWORD_W-2:0]};
    wire [DWORD_W-1:0]  s_res  = sh_left ? (sh_arith ? s_sla : s_shl)
                                         : (sh_arith ? s_sra : s_shr);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < STK_DEPTH; i++)
                stk_q[i] <= '0;
        end
        else if (sh_fire)
        begin
            stk_q[s_idx] <= s_res[DWORD_W-1:WORD_W];
            stk_q[s_odd] <= s_res[WORD_W-1:0];
        end
        else if (wr_fire)
            stk_q[w_idx] <= w_word;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reloc_q <= '0;
        else if (reloc_wr)
            reloc_q <= reloc_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_err_q <= 1'b0;
            sh_err_q <= 1'b0;
        end
        else
        begin
            wr_err_q <= wr_en & (~w_ok | sh_en);
            sh_err_q <= sh_en & ~s_ok;
        end
    end

    prx_fmt_if fi ();

    assign fi.chk_addr   = chk_addr;
    assign fi.chk_unit   = chk_unit;
    assign fi.chk_ilen   = chk_ilen;
    assign fi.chk_dlen   = chk_dlen;
    assign fi.opw        = stk_q[r_idx];
    assign fi.dec_packed = dec_packed;

    prx_fmt u_fmt
    (
        .f (fi.fmt)
    );

    // read shows the word as it stood before any write in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q     <= '0;
            rd_valid_q    <= 1'b0;
            rd_err_q      <= 1'b0;
            rd_neg_q      <= 1'b0;
            rd_fp_char_q  <= '0;
            rd_fp_exp_q   <= '0;
            rd_dec_sign_q <= '0;
        end
        else
        begin
            rd_valid_q <= rd_en & r_ok;
            rd_err_q   <= rd_en & ~r_ok;
            if (rd_en & r_ok)
            begin
                rd_data_q     <= fi.opw;
                rd_neg_q      <= fi.fix_neg;
                rd_fp_char_q  <= fi.fp_char;
                rd_fp_exp_q   <= fi.fp_exp;
                rd_dec_sign_q <= fi.dec_sign;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_valid_q <= 1'b0;
            misalign_q  <= 1'b0;
            len_err_q   <= 1'b0;
        end
        else
        begin
            chk_valid_q <= chk_en;
            misalign_q  <= chk_en & fi.misalign;
            len_err_q   <= chk_en & fi.len_bad;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_bank_sup;
        wr_fire && wr_kind == K_GEN && !problem_state_bit
        |=> stk_q[$past(wr_num)] == $past(wr_data);
    endproperty
    a_bank_sup: assert property (p_bank_sup) else $error("supervisor bank write misplaced");

    property p_bank_prob;
        wr_fire && wr_kind == K_GEN && problem_state_bit
        |=> stk_q[PROB_BASE + {2'h0, $past(wr_num)}] == $past(wr_data);
    endproperty
    a_bank_prob: assert property (p_bank_prob) else $error("problem bank write misplaced");

    property p_byte_keep;
        wr_fire && wr_kind == K_BYTE
        |=> stk_q[$past(w_idx)][WORD_W-1:BYTE_W] == $past(stk_q[w_idx][WORD_W-1:BYTE_W])
            && stk_q[$past(w_idx)][BYTE_W-1:0] == $past(wr_data[BYTE_W-1:0]);
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("byte write touched upper bits");

    property p_fps_low;
        wr_fire && wr_kind == K_FPS
        |=> stk_q[FP_BASE + {2'h0, $past(wr_num[3:1]), 1'b1}] == $past(stk_q[FP_BASE + {2'h0, wr_num[3:1], 1'b1}]);
    endproperty
    a_fps_low: assert property (p_fps_low) else $error("short float write changed low half");

    property p_pair_odd;
        rd_en && (rd_kind == K_PAIR || rd_kind == K_FPL) && rd_num[0] |=> rd_err_q && !rd_valid_q;
    endproperty
    a_pair_odd: assert property (p_pair_odd) else $error("odd pair number not refused");

    property p_word_align;
        chk_en && chk_unit == U_WORD |=> misalign_q == ($past(chk_addr[1:0]) != 2'h0);
    endproperty
    a_word_align: assert property (p_word_align) else $error("word alignment flag wrong");

    property p_var_free;
        chk_en && (chk_unit == U_VAR || chk_unit == U_BYTE) |=> chk_valid_q && !misalign_q;
    endproperty
    a_var_free: assert property (p_var_free) else $error("variable field flagged");

    property p_instr_align;
        chk_en && chk_unit == U_INSTR && chk_addr[0] |=> misalign_q;
    endproperty
    a_instr_align: assert property (p_instr_align) else $error("odd fetch address missed");

    property p_reloc;
        reloc_wr ##1 !reloc_wr |-> reloc_q == $past(reloc_data) ##1 reloc_q == $past(reloc_q);
    endproperty
    a_reloc: assert property (p_reloc) else $error("relocation register wrong");

    property p_shl1;
        sh_fire && sh_left && !sh_arith && sh_amt == 6'h01
        |=> {stk_q[$past(s_idx)], stk_q[$past(s_odd)]} == {$past(s_opnd[DWORD_W-2:0]), 1'b0};
    endproperty
    a_shl1: assert property (p_shl1) else $error("pair shift wrong");

    property p_fp_exp;
        rd_valid_q |-> rd_fp_exp_q == {1'b0, rd_data_q[FP_CHAR_HI:FP_CHAR_LO]} - FP_BIAS
                       && rd_neg_q == rd_data_q[SIGN_POS];
    endproperty
    a_fp_exp: assert property (p_fp_exp) else $error("float fields decoded wrongly");

    // a refused number must never reach the stack; control learns of it one cycle later
    property p_work_refuse;
        wr_en && wr_kind == K_WORK && wr_num[NUM_W-1] |=> wr_err_q;
    endproperty
    a_work_refuse: assert property (p_work_refuse) else $error("working index above seven accepted");

    property p_fp_refuse;
        wr_en && (wr_kind == K_FPS || wr_kind == K_FPL) && (wr_num[0] || wr_num[NUM_W-1])
        |=> wr_err_q;
    endproperty
    a_fp_refuse: assert property (p_fp_refuse) else $error("bad floating register number accepted");

    property p_pair_even;
        wr_fire && wr_kind == K_PAIR && !wr_half && !problem_state_bit
        |=> stk_q[$past(wr_num)] == $past(wr_data);
    endproperty
    a_pair_even: assert property (p_pair_even) else $error("high half of pair not in even register");

    property p_sra_sign;
        sh_fire && !sh_left && sh_arith && s_opnd[DWORD_W-1]
        |=> stk_q[$past(s_idx)][WORD_W-1];
    endproperty
    a_sra_sign: assert property (p_sra_sign) else $error("right arithmetic shift lost the sign");

    property p_half_align;
        chk_en && chk_unit == U_HALF |=> misalign_q == $past(chk_addr[0]);
    endproperty
    a_half_align: assert property (p_half_align) else $error("half word alignment flag wrong");

    property p_dbl_align;
        chk_en && chk_unit == U_DBL |=> misalign_q == ($past(chk_addr[2:0]) != 3'h0);
    endproperty
    a_dbl_align: assert property (p_dbl_align) else $error("double word alignment flag wrong");

    property p_dec_len;
        chk_en && chk_unit == U_VAR
        |=> len_err_q == ($past(chk_dlen) < DEC_LEN_MIN || $past(chk_dlen) > DEC_LEN_MAX);
    endproperty
    a_dec_len: assert property (p_dec_len) else $error("decimal length check wrong");

    property p_fixed_len;
        chk_en && (chk_unit == U_HALF || chk_unit == U_WORD || chk_unit == U_DBL || chk_unit == U_BYTE)
        |=> chk_valid_q && !len_err_q;
    endproperty
    a_fixed_len: assert property (p_fixed_len) else $error("fixed unit given a length error");

    property p_chk_pulse;
        !chk_en |=> !chk_valid_q && !misalign_q && !len_err_q;
    endproperty
    a_chk_pulse: assert property (p_chk_pulse) else $error("check result outlived its request");

    c_shift:    cover property (sh_fire ##3 rd_valid_q);
    c_misalign: cover property (chk_en && chk_unit == U_DBL ##1 misalign_q);
    c_prob_wr:  cover property (wr_fire && problem_state_bit && wr_kind == K_PAIR);
    c_fpl_rd:   cover property (rd_en && rd_kind == K_FPL ##1 rd_valid_q);
endmodule

//--- tb/prx_ctl_model.sv
// execution-side control model that issues stack commands on the falling edge
// assumes it shares the processor clock with the stack; the bench calls its tasks
`timescale 1ns/100ps
module prx_ctl_model
(
    input  wire logic                        clk,
    output logic                             problem_state_bit,
    output logic                             wr_en,
    output prx_pkg::prx_kind_t               wr_kind,
    output logic [prx_pkg::NUM_W-1:0]        wr_num,
    output logic                             wr_half,
    output logic [prx_pkg::WORD_W-1:0]       wr_data,
    output logic                             rd_en,
    output prx_pkg::prx_kind_t               rd_kind,
    output logic [prx_pkg::NUM_W-1:0]        rd_num,
    output logic                             rd_half,
    output logic                             dec_packed,
    output logic                             sh_en,
    output logic [prx_pkg::NUM_W-1:0]        sh_num,
    output logic                             sh_left,
    output logic                             sh_arith,
    output logic [prx_pkg::AMT_W-1:0]        sh_amt,
    output logic                             reloc_wr,
    output logic [prx_pkg::RELOC_W-1:0]      reloc_data,
    output logic                             chk_en,
    output prx_pkg::prx_unit_t               chk_unit,
    output logic [prx_pkg::ADDR_W-1:0]       chk_addr,
    output logic [1:0]                       chk_ilen,
    output logic [4:0]                       chk_dlen
);
    import prx_pkg::*;
    initial
    begin
        {problem_state_bit, wr_en, wr_half, rd_en, rd_half, dec_packed} = 6'h00;
        {sh_en, sh_left, sh_arith, reloc_wr, chk_en} = 5'h00;
        wr_kind = K_GEN;
        rd_kind = K_GEN;
        chk_unit = U_BYTE;
        {wr_num, rd_num, sh_num, sh_amt} = 18'h00000;
        {wr_data, reloc_data, chk_addr} = 76'h0;
        {chk_ilen, chk_dlen} = 7'h00;
    end
    // each request stands for one full cycle; released write and relocation data is inverted so stale values never pass
    task automatic wr(input prx_kind_t k, input logic [3:0] n, input logic h, input logic [31:0] d);
        @(negedge clk);
        {wr_en, wr_num, wr_half, wr_data} = {1'b1, n, h, d};
        wr_kind = k;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~wr_data;
    endtask
    task automatic rd(input prx_kind_t k, input logic [3:0] n, input logic h);
        @(negedge clk);
        {rd_en, rd_num, rd_half} = {1'b1, n, h};
        rd_kind = k;
        @(negedge clk);
        rd_en = 1'b0;
    endtask
    task automatic sh(input logic [3:0] n, input logic l, input logic a, input logic [5:0] amt);
        @(negedge clk);
        {sh_en, sh_num, sh_left, sh_arith, sh_amt} = {1'b1, n, l, a, amt};
        @(negedge clk);
        sh_en = 1'b0;
    endtask
    task automatic rel(input logic [19:0] d);
        @(negedge clk);
        {reloc_wr, reloc_data} = {1'b1, d};
        @(negedge clk);
        reloc_wr = 1'b0;
        reloc_data = ~reloc_data;
    endtask
    task automatic chk(input prx_unit_t u, input logic [23:0] a, input logic [1:0] il, input logic [4:0] dl);
        @(negedge clk);
        {chk_en, chk_addr, chk_ilen, chk_dlen} = {1'b1, a, il, dl};
        chk_unit = u;
        @(negedge clk);
        chk_en = 1'b0;
    endtask
    // instruction fetches from control always land on a half-word boundary
    task automatic fetch(input logic [23:0] a);
        chk(U_INSTR, {a[23:1], 1'b0}, 2'h2, 5'h01);
    endtask
    // problem state and decimal form are levels; callers change them only between requests
    task automatic mode(input logic p, input logic dp);
        problem_state_bit = p;
        dec_packed = dp;
    endtask
endmodule

//--- tb/prx_regstack_test.sv
// self-checking bench for the processor register stack
// assumes the control model drives every stack input except clk and rst_n, which the bench drives itself; rst_n is raised on a falling edge
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module prx_regstack_test;
    import prx_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic problem_state_bit, wr_en, wr_half, rd_en, rd_half, dec_packed, sh_en, sh_left, sh_arith;
    logic reloc_wr, chk_en, rd_valid_q, rd_err_q, rd_neg_q, wr_err_q, sh_err_q;
    logic chk_valid_q, misalign_q, len_err_q;
    prx_kind_t wr_kind, rd_kind;
    prx_unit_t chk_unit;
    logic [3:0] wr_num, rd_num, sh_num, rd_dec_sign_q;
    logic [5:0] sh_amt;
    logic [31:0] wr_data, rd_data_q;
    logic [19:0] reloc_data, reloc_q;
    logic [23:0] chk_addr;
    logic [1:0] chk_ilen;
    logic [4:0] chk_dlen;
    logic [6:0] rd_fp_char_q;
    logic [7:0] rd_fp_exp_q;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    prx_ctl_model m (.clk, .problem_state_bit, .wr_en, .wr_kind, .wr_num, .wr_half, .wr_data, .rd_en,
        .rd_kind, .rd_num, .rd_half, .dec_packed, .sh_en, .sh_num, .sh_left, .sh_arith, .sh_amt,
        .reloc_wr, .reloc_data, .chk_en, .chk_unit, .chk_addr, .chk_ilen, .chk_dlen);
    prx_regstack dut (.clk, .rst_n, .problem_state_bit, .wr_en, .wr_kind, .wr_num, .wr_half, .wr_data,
        .rd_en, .rd_kind, .rd_num, .rd_half, .dec_packed, .sh_en, .sh_num, .sh_left, .sh_arith, .sh_amt,
        .reloc_wr, .reloc_data, .chk_en, .chk_unit, .chk_addr, .chk_ilen, .chk_dlen, .rd_data_q,
        .rd_valid_q, .rd_err_q, .rd_neg_q, .rd_fp_char_q, .rd_fp_exp_q, .rd_dec_sign_q, .wr_err_q,
        .sh_err_q, .reloc_q, .chk_valid_q, .misalign_q, .len_err_q);

    always #20 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // runaway guard: the whole sequence needs well under 300 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic rchk(input prx_kind_t k, input logic [3:0] n, input logic h, input logic [31:0] e);
        m.rd(k, n, h);
        `CHK(rd_valid_q, 1'b1)
        `CHK(rd_data_q, e)
    endtask
    task automatic wbad(input prx_kind_t k, input logic [3:0] n);
        m.wr(k, n, 1'b0, 32'h5A5A_5A5A);
        `CHK(wr_err_q, 1'b1)
    endtask

    task automatic t_bank();
        m.mode(1'b0, 1'b0);
        m.wr(K_GEN, 4'h3, 1'b0, 32'h1111_2222);
        m.mode(1'b1, 1'b0);
        m.wr(K_GEN, 4'h3, 1'b0, 32'h8000_0005);
        rchk(K_GEN, 4'h3, 1'b0, 32'h8000_0005);
        `CHK(rd_neg_q, 1'b1)
        m.mode(1'b0, 1'b0);
        rchk(K_GEN, 4'h3, 1'b0, 32'h1111_2222);
        `CHK(rd_neg_q, 1'b0)
        m.wr(K_BYTE, 4'h3, 1'b0, 32'hFFFF_FFAB);
        rchk(K_GEN, 4'h3, 1'b0, 32'h1111_22AB);
    endtask

    task automatic t_fp();
        m.wr(K_FPL, 4'h2, 1'b0, 32'hC212_3456);
        m.wr(K_FPL, 4'h2, 1'b1, 32'h89AB_CDEF);
        rchk(K_FPL, 4'h2, 1'b0, 32'hC212_3456);
        `CHK({rd_neg_q, rd_fp_char_q}, 8'hC2)
        `CHK(rd_fp_exp_q, 8'h02)
        m.wr(K_FPS, 4'h2, 1'b0, 32'h3F00_0001);
        rchk(K_FPL, 4'h2, 1'b1, 32'h89AB_CDEF);
        rchk(K_FPS, 4'h2, 1'b0, 32'h3F00_0001);
        `CHK(rd_fp_exp_q, 8'hFF)
        wbad(K_FPS, 4'h3);
        wbad(K_FPL, 4'h8);
    endtask

    task automatic t_work();
        m.wr(K_WORK, 4'h7, 1'b0, 32'h0000_00DC);
        m.mode(1'b0, 1'b1);
        rchk(K_WORK, 4'h7, 1'b0, 32'h0000_00DC);
        `CHK(rd_dec_sign_q, 4'hC)
        m.mode(1'b0, 1'b0);
        rchk(K_WORK, 4'h7, 1'b0, 32'h0000_00DC);
        `CHK(rd_dec_sign_q, 4'hD)
        wbad(K_WORK, 4'h8);
        m.rd(K_WORK, 4'h8, 1'b0);
        `CHK({rd_valid_q, rd_err_q}, 2'b01)
    endtask

    task automatic t_pair();
        m.wr(K_PAIR, 4'h4, 1'b0, 32'h8000_0001);
        m.wr(K_PAIR, 4'h4, 1'b1, 32'hF000_0000);
        rchk(K_GEN, 4'h4, 1'b0, 32'h8000_0001);
        m.sh(4'h4, 1'b1, 1'b0, 6'h04);
        rchk(K_GEN, 4'h4, 1'b0, 32'h0000_001F);
        rchk(K_PAIR, 4'h4, 1'b1, 32'h0000_0000);
        m.wr(K_GEN, 4'h4, 1'b0, 32'h8000_0000);
        m.sh(4'h4, 1'b0, 1'b1, 6'h04);
        rchk(K_GEN, 4'h4, 1'b0, 32'hF800_0000);
        m.sh(4'h4, 1'b1, 1'b0, 6'h01);
        rchk(K_GEN, 4'h4, 1'b0, 32'hF000_0000);
        m.sh(4'h4, 1'b1, 1'b1, 6'h04);
        rchk(K_GEN, 4'h4, 1'b0, 32'h8000_0000);
        m.sh(4'h4, 1'b0, 1'b0, 6'h04);
        rchk(K_GEN, 4'h4, 1'b0, 32'h0800_0000);
        m.rd(K_PAIR, 4'h5, 1'b0);
        `CHK({rd_valid_q, rd_err_q}, 2'b01)
        m.sh(4'h5, 1'b1, 1'b0, 6'h01);
        `CHK(sh_err_q, 1'b1)
        wbad(K_PAIR, 4'h5);
    endtask

    task automatic c1(input prx_unit_t u, input logic [23:0] a, input logic [1:0] il, input logic [4:0] dl,
                      input logic em, input logic el);
        m.chk(u, a, il, dl);
        `CHK({chk_valid_q, misalign_q, len_err_q}, {1'b1, em, el})
    endtask

    task automatic t_align();
        c1(U_HALF, 24'h000001, 2'h1, 5'h01, 1'b1, 1'b0);
        c1(U_HALF, 24'h000002, 2'h1, 5'h01, 1'b0, 1'b0);
        c1(U_WORD, 24'h000002, 2'h1, 5'h01, 1'b1, 1'b0);
        c1(U_WORD, 24'h000004, 2'h1, 5'h01, 1'b0, 1'b0);
        c1(U_DBL, 24'h000004, 2'h1, 5'h01, 1'b1, 1'b0);
        c1(U_DBL, 24'h000008, 2'h1, 5'h01, 1'b0, 1'b0);
        c1(U_BYTE, 24'h000003, 2'h1, 5'h01, 1'b0, 1'b0);
        c1(U_VAR, 24'h000007, 2'h1, 5'h10, 1'b0, 1'b0);
        c1(U_VAR, 24'h000007, 2'h1, 5'h11, 1'b0, 1'b1);
        c1(U_VAR, 24'h000000, 2'h1, 5'h00, 1'b0, 1'b1);
        c1(U_INSTR, 24'h000002, 2'h0, 5'h01, 1'b0, 1'b1);
        c1(U_INSTR, 24'h000001, 2'h3, 5'h01, 1'b1, 1'b0);
        m.fetch(24'h000005);
        `CHK({misalign_q, len_err_q}, 2'b00)
        m.rel(20'hABCDE);
        `CHK(reloc_q, 20'hABCDE)
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        `CHK(reloc_q, 20'h00000)
        rst_n = 1'b1;
        t_bank();
        t_fp();
        t_work();
        t_pair();
        t_align();
        print_verdict();
    end
endmodule
